// File: src/bmss_boot_mode_strap_select.sv
// Start-up strap decode and mode-dependent host pin configuration
`timescale 1ns/1ps
`default_nettype none
module bmss_boot_mode_strap_select (
  input  wire logic core_clk,
  input  wire logic reset,
  // Strap pins
  input  wire logic test_strap_n,
  input  wire logic loader_strap,
  output logic      test_strap_in_en_r,
  output logic      test_strap_pull_up_r,
  output logic      loader_strap_in_en_r,
  output logic      loader_strap_pull_down_r,
  // Reset pin
  input  wire logic reset_in_n,
  output logic      reset_pull_up_r,
  output logic      reset_request_r,
  // Power mode from the core
  input  wire logic low_power_serial_mode,
  input  wire logic system_off_mode,
  // Wake pins
  input  wire logic wake_request_in_n,
  output logic      wake_request_in_en_r,
  output logic      wake_request_r,
  input  wire logic wake_indicate_req,
  output logic      wake_indicate_out_n,
  output logic      wake_indicate_oe_r,
  // Two-wire pins, kept off
  input  wire logic two_wire_data_in,
  output logic      two_wire_data_out,
  output logic      two_wire_data_oe,
  input  wire logic two_wire_clock_in,
  output logic      two_wire_clock_out,
  output logic      two_wire_clock_oe,
  // Serial port toward the host
  input  wire logic serial_rx_pin,
  output logic      serial_rx_data_r,
  input  wire logic serial_tx_data,
  output logic      serial_tx_pin_r,
  output logic      serial_tx_oe_r,
  input  wire logic rts_in_n,
  output logic      rts_pull_down_r,
  output logic      rts_asserted_r,
  input  wire logic cts_req,
  output logic      cts_out_n_r,
  output logic      cts_oe_r,
  // Decoded mode
  output logic      mode_valid_r,
  output logic      mode_vendor_test_r,
  output logic      mode_direct_test_r,
  output logic      mode_bootloader_r,
  output logic      mode_firmware_r,
  output logic      bootloader_start_r,
  output logic      serial_port_en_r,
  output logic      direct_test_link_r
);

  logic [bmss_pkg::PIN_W-1:0]        pins_s;
  bmss_pkg::bmss_state_t             state_r;
  bmss_pkg::bmss_state_t             state_nxt;
  bmss_pkg::bmss_mode_t              mode_r;
  bmss_pkg::bmss_mode_t              mode_nxt;
  logic [bmss_pkg::SETTLE_CNT_W-1:0] cnt_r;
  logic [bmss_pkg::SETTLE_CNT_W-1:0] cnt_nxt;
  logic                              test_act;
  logic                              loader_act;
  logic                              normal_pads;

  bmss_sync #(
    .WIDTH    (bmss_pkg::PIN_W),
    .IDLE_VAL (bmss_pkg::PIN_IDLE)
  ) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   ({reset_in_n, rts_in_n, serial_rx_pin, wake_request_in_n,
                loader_strap, test_strap_n}),
    .sync_out (pins_s)
  );

  assign test_act   = ~pins_s[bmss_pkg::PIN_TEST_N];
  assign loader_act = pins_s[bmss_pkg::PIN_LOADER];

  // Strap capture sequence
  always_comb begin
    state_nxt = state_r;
    mode_nxt  = mode_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      bmss_pkg::BMSS_ST_SETTLE: begin
        // Waits for pulls to settle and the synchroniser to fill
        if (cnt_r == bmss_pkg::SETTLE_CNT_W'(bmss_pkg::STRAP_SETTLE_CYC - 1)) begin
          state_nxt = bmss_pkg::BMSS_ST_SAMPLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      bmss_pkg::BMSS_ST_SAMPLE: begin
        state_nxt = bmss_pkg::BMSS_ST_RUN;
        case ({test_act, loader_act})
          2'b10:   mode_nxt = bmss_pkg::BMSS_MODE_VENDOR;
          2'b11:   mode_nxt = bmss_pkg::BMSS_MODE_DTM;
          2'b01:   mode_nxt = bmss_pkg::BMSS_MODE_LOADER;
          default: mode_nxt = bmss_pkg::BMSS_MODE_FIRMWARE;
        endcase
      end
      // Latched until the next reset; later strap changes ignored
      bmss_pkg::BMSS_ST_RUN: state_nxt = bmss_pkg::BMSS_ST_RUN;
      default: begin
        state_nxt = bmss_pkg::BMSS_ST_SETTLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r <= bmss_pkg::BMSS_ST_SETTLE;
      mode_r  <= bmss_pkg::BMSS_MODE_NONE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Straps must stay readable until captured, whatever the power mode
  assign normal_pads = (state_r != bmss_pkg::BMSS_ST_RUN) ||
                       (~low_power_serial_mode && ~system_off_mode);

  // Pad configuration and mode outputs, all registered
  logic pad_test_ie_nxt;
  logic pad_loader_ie_nxt;
  logic wake_en_nxt;
  logic lps_nxt;
  logic reset_request_nxt;
  logic wake_request_nxt;
  logic wake_indicate_nxt;
  logic serial_rx_nxt;
  logic serial_tx_nxt;
  logic rts_asserted_nxt;
  logic cts_out_n_nxt;
  logic mode_valid_nxt;
  logic mode_vendor_nxt;
  logic mode_direct_nxt;
  logic mode_loader_nxt;
  logic mode_firmware_nxt;
  logic boot_start_nxt;
  logic dtm_link_nxt;

  always_comb begin
    lps_nxt           = low_power_serial_mode && ~system_off_mode &&
                        (state_r == bmss_pkg::BMSS_ST_RUN);
    pad_test_ie_nxt   = normal_pads;
    pad_loader_ie_nxt = normal_pads;
    wake_en_nxt       = lps_nxt;
    reset_request_nxt = ~pins_s[bmss_pkg::PIN_RESET_N];
    wake_request_nxt  = lps_nxt & ~pins_s[bmss_pkg::PIN_WAKE_N];
    wake_indicate_nxt = ~(lps_nxt & wake_indicate_req);
    serial_rx_nxt     = pins_s[bmss_pkg::PIN_RX];
    serial_tx_nxt     = serial_tx_data;
    // Pulled down when open, so a missing host reads as ready
    rts_asserted_nxt  = ~pins_s[bmss_pkg::PIN_RTS_N];
    cts_out_n_nxt     = ~cts_req;
    mode_valid_nxt    = (state_r == bmss_pkg::BMSS_ST_RUN);
    mode_vendor_nxt   = (mode_r == bmss_pkg::BMSS_MODE_VENDOR);
    mode_direct_nxt   = (mode_r == bmss_pkg::BMSS_MODE_DTM);
    mode_loader_nxt   = (mode_r == bmss_pkg::BMSS_MODE_LOADER);
    mode_firmware_nxt = (mode_r == bmss_pkg::BMSS_MODE_FIRMWARE);
    // Firmware combination also passes through the update loader first
    boot_start_nxt    = mode_loader_nxt || mode_firmware_nxt;
    dtm_link_nxt      = mode_direct_nxt;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      test_strap_in_en_r       <= 1'b1;
      test_strap_pull_up_r     <= 1'b1;
      loader_strap_in_en_r     <= 1'b1;
      loader_strap_pull_down_r <= 1'b1;
      reset_pull_up_r          <= 1'b1;
      reset_request_r          <= 1'b0;
      wake_request_in_en_r     <= 1'b0;
      wake_request_r           <= 1'b0;
      wake_indicate_out_n      <= 1'b1;
      wake_indicate_oe_r       <= 1'b0;
      serial_rx_data_r         <= 1'b1;
      serial_tx_pin_r          <= 1'b1;
      serial_tx_oe_r           <= 1'b0;
      rts_pull_down_r          <= 1'b1;
      rts_asserted_r           <= 1'b0;
      cts_out_n_r              <= 1'b1;
      cts_oe_r                 <= 1'b0;
      mode_valid_r             <= 1'b0;
      mode_vendor_test_r       <= 1'b0;
      mode_direct_test_r       <= 1'b0;
      mode_bootloader_r        <= 1'b0;
      mode_firmware_r          <= 1'b0;
      bootloader_start_r       <= 1'b0;
      serial_port_en_r         <= 1'b0;
      direct_test_link_r       <= 1'b0;
      two_wire_data_out        <= 1'h0;
      two_wire_data_oe         <= 1'h0;
      two_wire_clock_out       <= 1'h0;
      two_wire_clock_oe        <= 1'h0;
    end else begin
      test_strap_in_en_r       <= pad_test_ie_nxt;
      test_strap_pull_up_r     <= pad_test_ie_nxt;
      loader_strap_in_en_r     <= pad_loader_ie_nxt;
      loader_strap_pull_down_r <= pad_loader_ie_nxt;
      reset_pull_up_r          <= 1'h1;
      reset_request_r          <= reset_request_nxt;
      wake_request_in_en_r     <= wake_en_nxt;
      wake_request_r           <= wake_request_nxt;
      wake_indicate_out_n      <= wake_indicate_nxt;
      wake_indicate_oe_r       <= wake_en_nxt;
      serial_rx_data_r         <= serial_rx_nxt;
      serial_tx_pin_r          <= serial_tx_nxt;
      serial_tx_oe_r           <= 1'h1;
      rts_pull_down_r          <= 1'h1;
      rts_asserted_r           <= rts_asserted_nxt;
      cts_out_n_r              <= cts_out_n_nxt;
      cts_oe_r                 <= 1'h1;
      mode_valid_r             <= mode_valid_nxt;
      mode_vendor_test_r       <= mode_vendor_nxt;
      mode_direct_test_r       <= mode_direct_nxt;
      mode_bootloader_r        <= mode_loader_nxt;
      mode_firmware_r          <= mode_firmware_nxt;
      bootloader_start_r       <= boot_start_nxt;
      serial_port_en_r         <= 1'h1;
      direct_test_link_r       <= dtm_link_nxt;
      // Two-wire pads are never driven in any mode
      two_wire_data_out        <= 1'h0;
      two_wire_data_oe         <= 1'h0;
      two_wire_clock_out       <= 1'h0;
      two_wire_clock_oe        <= 1'h0;
    end
  end

endmodule : bmss_boot_mode_strap_select
`default_nettype wire

// File: src/bmss_pkg.sv
// Constants, states and modes for the start-up strap and pin configuration block
`default_nettype none
package bmss_pkg;

  localparam int unsigned CLK_PERIOD_PS    = 5000;
  // Pad and strap network settling time after reset release
  localparam int unsigned STRAP_SETTLE_NS  = 100;
  localparam int unsigned STRAP_SETTLE_CYC =
    ((STRAP_SETTLE_NS * 1000) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_CNT_W     = 8;

  // Bit positions in the synchronised pin vector
  localparam int unsigned PIN_W        = 6;
  localparam int unsigned PIN_TEST_N   = 0;
  localparam int unsigned PIN_LOADER   = 1;
  localparam int unsigned PIN_WAKE_N   = 2;
  localparam int unsigned PIN_RX       = 3;
  localparam int unsigned PIN_RTS_N    = 4;
  localparam int unsigned PIN_RESET_N  = 5;
  // Idle levels of the pins while the synchroniser is in reset
  localparam logic [PIN_W-1:0] PIN_IDLE = 6'h3d;

  typedef enum logic [2:0] {
    BMSS_ST_SETTLE = 3'h1,
    BMSS_ST_SAMPLE = 3'h2,
    BMSS_ST_RUN    = 3'h4
  } bmss_state_t;

  typedef enum logic [3:0] {
    BMSS_MODE_NONE     = 4'h0,
    BMSS_MODE_VENDOR   = 4'h1,
    BMSS_MODE_DTM      = 4'h2,
    BMSS_MODE_LOADER   = 4'h4,
    BMSS_MODE_FIRMWARE = 4'h8
  } bmss_mode_t;

endpackage : bmss_pkg
`default_nettype wire

// File: src/bmss_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module bmss_sync #(
  parameter int unsigned       WIDTH    = 1,
  parameter logic [WIDTH-1:0]  IDLE_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r   <= IDLE_VAL;
      sync_out <= IDLE_VAL;
    end else begin
      meta_r   <= pin_in;
      sync_out <= meta_r;
    end
  end

endmodule : bmss_sync
`default_nettype wire

// File: tb/bmss_assertions.sv
// Concurrent checks on strap decode and host pin configuration
`timescale 1ns/1ps
`default_nettype none
module bmss_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic low_power_serial_mode,
  input wire logic system_off_mode,
  input wire logic wake_request_in_en_r,
  input wire logic test_strap_in_en_r,
  input wire logic loader_strap_pull_down_r,
  input wire logic two_wire_data_oe,
  input wire logic two_wire_clock_oe,
  input wire logic serial_tx_data,
  input wire logic serial_tx_pin_r,
  input wire logic mode_valid_r,
  input wire logic mode_vendor_test_r,
  input wire logic mode_direct_test_r,
  input wire logic mode_bootloader_r,
  input wire logic mode_firmware_r,
  input wire logic bootloader_start_r,
  input wire logic serial_port_en_r,
  input wire logic direct_test_link_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wake_on_a: assert property (
    mode_valid_r && low_power_serial_mode && !system_off_mode |=> wake_request_in_en_r)
    else $error("wake enable missing");
  wake_off_a: assert property (
    !low_power_serial_mode || system_off_mode |=> !wake_request_in_en_r)
    else $error("wake enable outside low power serial");
  strap_off_a: assert property (
    mode_valid_r && (low_power_serial_mode || system_off_mode)
    |=> !test_strap_in_en_r && !loader_strap_pull_down_r) else $error("strap pads left on");
  two_wire_off_a: assert property (
    !two_wire_data_oe && !two_wire_clock_oe) else $error("two wire pin driven");
  tx_follow_a: assert property (
    !$past(reset) |-> serial_tx_pin_r == $past(serial_tx_data)) else $error("tx pin lag");
  mode_onehot_a: assert property (
    mode_valid_r |-> $onehot({mode_vendor_test_r, mode_direct_test_r, mode_bootloader_r,
    mode_firmware_r})) else $error("mode not one hot");
  mode_hold_a: assert property (
    mode_valid_r && $past(mode_valid_r) |-> $stable({mode_vendor_test_r, mode_direct_test_r,
    mode_bootloader_r, mode_firmware_r})) else $error("mode changed");
  mode_use_a: assert property (
    mode_valid_r |-> bootloader_start_r == (mode_bootloader_r || mode_firmware_r)
    && serial_port_en_r && direct_test_link_r == mode_direct_test_r) else $error("mode use");
endmodule : bmss_assertions
bind bmss_boot_mode_strap_select bmss_assertions i_chk (.*);
`default_nettype wire

// File: tb/bmss_host_model.sv
// Host terminal model on the serial port with hardware handshake
`timescale 1ns/1ps
`default_nettype none
module bmss_host_model (
  input  wire logic core_clk,
  input  wire logic host_bit,
  input  wire logic host_stall,
  input  wire logic cts_out_n_r,
  output var  logic serial_rx_pin,
  output var  logic rts_in_n
);
  initial begin
    serial_rx_pin = 1'b1;
    rts_in_n      = 1'b1;
    forever begin
      @(posedge core_clk);
      rts_in_n      <= host_stall;
      // Sends only while cleared, idles at mark otherwise
      serial_rx_pin <= cts_out_n_r ? 1'b1 : host_bit;
    end
  end
endmodule : bmss_host_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for strap decode and host pin configuration
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0, reset = 1'b1, test_strap_n = 1'b1, loader_strap = 1'b0;
  logic reset_in_n = 1'b1, low_power_serial_mode = 1'b0, system_off_mode = 1'b0;
  logic wake_request_in_n = 1'b1, wake_indicate_req = 1'b0, two_wire_data_in = 1'b0;
  logic two_wire_clock_in = 1'b0, serial_tx_data = 1'b1, cts_req = 1'b0;
  logic host_bit = 1'b1, host_stall = 1'b0, serial_rx_pin, rts_in_n;
  logic test_strap_in_en_r, test_strap_pull_up_r, loader_strap_in_en_r, reset_pull_up_r;
  logic loader_strap_pull_down_r, reset_request_r, wake_request_in_en_r, wake_request_r;
  logic wake_indicate_out_n, wake_indicate_oe_r, two_wire_data_out, two_wire_data_oe;
  logic two_wire_clock_out, two_wire_clock_oe, serial_rx_data_r, serial_tx_pin_r;
  logic serial_tx_oe_r, rts_pull_down_r, rts_asserted_r, cts_out_n_r, cts_oe_r;
  logic mode_valid_r, mode_vendor_test_r, mode_direct_test_r, mode_bootloader_r;
  logic mode_firmware_r, bootloader_start_r, serial_port_en_r, direct_test_link_r;
  int failures = 0, tests_run = 0, cycles = 0;
  logic [1:0] straps [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  // Expected {vendor, direct, loader, firmware}
  logic [3:0] modes [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  bmss_boot_mode_strap_select i_dut (.*);
  bmss_host_model i_host (.*);
  always #2.5 core_clk = ~core_clk;
  task automatic chk(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Hang guard, run needs about 175 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      reset <= 1'b1;
      test_strap_n <= straps[i][1];
      loader_strap <= straps[i][0];
      tick(5);
      reset <= 1'b0;
      tick(24);
      // Straps flipped after capture must not move the mode
      test_strap_n <= ~straps[i][1];
      loader_strap <= ~straps[i][0];
      tick(6);
      chk("valid", 1'b1, mode_valid_r);
      chk("vendor", modes[i][3], mode_vendor_test_r);
      chk("direct", modes[i][2], mode_direct_test_r);
      chk("loader", modes[i][1], mode_bootloader_r);
      chk("firmware", modes[i][0], mode_firmware_r);
      chk("start", modes[i][1] | modes[i][0], bootloader_start_r);
      chk("link", modes[i][2], direct_test_link_r);
      chk("serial_en", 1'b1, serial_port_en_r);
    end
    for (int p = 0; p < 4; p++) begin
      low_power_serial_mode <= p[0];
      system_off_mode <= p[1];
      wake_indicate_req <= 1'b1;
      wake_request_in_n <= 1'b0;
      tick(4);
      chk("wake_en", p == 1, wake_request_in_en_r);
      chk("wake_req", p == 1, wake_request_r);
      chk("wake_ind", p != 1, wake_indicate_out_n);
      chk("test_en", p == 0, test_strap_in_en_r);
      chk("test_pu", p == 0, test_strap_pull_up_r);
      chk("load_pd", p == 0, loader_strap_pull_down_r);
      chk("load_en", p == 0, loader_strap_in_en_r);
      chk("wake_oe", p == 1, wake_indicate_oe_r);
      chk("twi_oe", 1'b0, two_wire_data_oe | two_wire_clock_oe);
      chk("twi_out", 1'b0, two_wire_data_out | two_wire_clock_out);
    end
    low_power_serial_mode <= 1'b0;
    system_off_mode <= 1'b0;
    serial_tx_data <= 1'b0;
    cts_req <= 1'b1;
    host_bit <= 1'b0;
    host_stall <= 1'b1;
    reset_in_n <= 1'b0;
    tick(2);
    chk("tx", 1'b0, serial_tx_pin_r);
    chk("tx_oe", 1'b1, serial_tx_oe_r);
    chk("cts", 1'b0, cts_out_n_r);
    chk("cts_oe", 1'b1, cts_oe_r);
    tick(5);
    chk("rx", 1'b0, serial_rx_data_r);
    chk("rts", 1'b0, rts_asserted_r);
    chk("rst_req", 1'b1, reset_request_r);
    chk("rst_pu", 1'b1, reset_pull_up_r);
    chk("rts_pd", 1'b1, rts_pull_down_r);
    cts_req <= 1'b0;
    host_stall <= 1'b0;
    serial_tx_data <= 1'b1;
    tick(6);
    chk("rx_idle", 1'b1, serial_rx_data_r);
    chk("rts", 1'b1, rts_asserted_r);
    chk("tx", 1'b1, serial_tx_pin_r);
    summarize();
  end
endmodule : tb
`default_nettype wire
